// File: hdl/fsp_status_protect.sv
// Overview of operation
// - Busy bit 0 set during operation, cleared after
// - While busy, ignore all but allowed opcodes
// - Busy bit is read only
// - Write-enable sets latch bit 1; reset clears
// - Write-disable or completion clears latch
// - Status write keeps latch until completion
// - Writes inhibited while latch is zero
// - Program and erase opcodes need latch
// - Nonvolatile register opcodes need latch
// - Volatile register opcodes ignore latch
// - Protect bits block program/erase in region
// - Chip erase only with protect bits zero
// - Disable bit plus low pin locks status
// - Otherwise status write updates bits 7..2
// - Quad bit turns protect pins into data
// - Bits 7..2 nonvolatile, default zero
// - Status readable at any time
// - Continuous read repeats status byte
// - Protect code to 64KB block range map
`timescale 1ns/10ps
`default_nettype none
module fsp_status_protect
  import fsp_pkg::*;
#(
  parameter int BUSY_CYCLES = BUSY_CYC_DEF
) (
  input  wire logic           mclk,
  input  wire logic           nrst,
  input  wire logic           ce,
  input  wire logic           sck,
  input  wire logic           cs_n,
  input  wire logic           si,
  input  wire logic           wp_n,
  output var  logic           so,
  output var  logic           so_en_n,
  output var  fsp_status_type status,
  output var  logic           quad_pins,
  output var  logic           op_go,
  output var  logic [7:0]     op_kind,
  output var  logic [23:0]    op_addr
);

  // ==========================================
  // Decode helpers
  function automatic logic is_array(input logic [7:0] o);
    return o == OPC_PP || o == OPC_PPQ_A || o == OPC_PPQ_B || o == OPC_SE_A
        || o == OPC_SE_B || o == OPC_BE32 || o == OPC_BE64;
  endfunction

  function automatic logic is_nvreg(input logic [7:0] o);
    return o == OPC_WRFN || o == OPC_SET_READ_PARAMS_NV_CMD || o == OPC_SERNV || o == OPC_INFO_ROW_ERASE_CMD
        || o == OPC_IRP || o == OPC_WRAB;
  endfunction

  function automatic logic is_erase_all(input logic [7:0] o);
    return o == OPC_CE_A || o == OPC_CE_B;
  endfunction

  function automatic logic busy_ok(input logic [7:0] o);
    return o == OPC_READ_STATUS_CMD || o == OPC_RDERP || o == OPC_SUS_A || o == OPC_SUS_B
        || o == OPC_RSTEN || o == OPC_RST;
  endfunction

  // Top codes grow down from block 63, bottom codes shrink from block 0
  function automatic logic blk_prot(input logic [3:0] bp, input logic [5:0] blk);
    logic [6:0] span;
    span = 7'h00;
    if (bp >= 4'h1 && bp <= 4'h6) begin
      span = 7'h01 << (bp - 4'h1);
      return {1'b0, blk} >= 7'h40 - span;
    end
    if (bp == 4'h7 || bp == 4'h8) begin
      return 1'b1;
    end
    if (bp >= 4'h9 && bp <= 4'he) begin
      span = 7'h40 >> (bp - 4'h8);
      return {1'b0, blk} < span;
    end
    return 1'b0;
  endfunction

  // ==========================================
  // Pin synchronisers
  fsp_pins_type pins_s1_r, pins_s2_r, pins_s3_r;
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pins_s1_r <= PINS_IDLE;
      pins_s2_r <= PINS_IDLE;
      pins_s3_r <= PINS_IDLE;
    end else if (ce) begin
      pins_s1_r <= '{sck: sck, cs_n: cs_n, si: si, wp_n: wp_n};
      pins_s2_r <= pins_s1_r;
      pins_s3_r <= pins_s2_r;
    end
  end

  logic sck_rise, sck_fall, cs_rise;
  assign sck_rise = pins_s2_r.sck & ~pins_s3_r.sck & ~pins_s2_r.cs_n;
  assign sck_fall = ~pins_s2_r.sck & pins_s3_r.sck & ~pins_s2_r.cs_n;
  assign cs_rise  = pins_s2_r.cs_n & ~pins_s3_r.cs_n;

  // ==========================================
  // Status storage
  logic             busy_r, wel_r, susp_r, rst_en_r;
  logic [5:0]       nv_r;
  logic [CNT_W-1:0] cnt_r;
  fsp_state_type    state_r;
  logic [7:0]       opc_r, data_r, in_sr_r, out_sr_r;
  logic [23:0]      addr_r;
  logic [2:0]       bit_cnt_r, byte_cnt_r, out_cnt_r;

  logic [3:0] bp;
  logic       wp_low, hw_lock;
  assign bp      = nv_r[SR_QE-SR_BP_LO-1:0];
  // In quad mode the pin is a data line, so it no longer locks anything
  assign wp_low  = ~pins_s2_r.wp_n & ~nv_r[SR_QE-SR_BP_LO];
  assign hw_lock = nv_r[SR_STATUS_WRITE_DISABLE-SR_BP_LO] & wp_low;

  // ==========================================
  // Command framing
  logic [7:0] byte_in;
  logic       byte_done, whole;
  assign byte_in   = {in_sr_r[6:0], pins_s2_r.si};
  assign byte_done = sck_rise && bit_cnt_r == 3'h7;
  assign whole     = bit_cnt_r == 3'h0;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
    end else if (ce) begin
      unique case (state_r)
        ST_IDLE: begin
          if (!pins_s2_r.cs_n) begin
            state_r <= ST_CMD;
          end
        end
        ST_CMD: begin
          if (pins_s2_r.cs_n) begin
            state_r <= ST_IDLE;
          end else if (byte_done && byte_cnt_r == 3'h0) begin
            if (busy_r && !busy_ok(byte_in)) begin
              state_r <= ST_SKIP;
            end else if (byte_in == OPC_READ_STATUS_CMD) begin
              state_r <= ST_READ;
            end
          end
        end
        ST_READ, ST_SKIP: begin
          if (pins_s2_r.cs_n) begin
            state_r <= ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      in_sr_r    <= 8'h00;
      bit_cnt_r  <= 3'h0;
      byte_cnt_r <= 3'h0;
      opc_r      <= 8'h00;
      addr_r     <= 24'h000000;
      data_r     <= 8'h00;
    end else if (ce) begin
      if (state_r == ST_IDLE) begin
        bit_cnt_r  <= 3'h0;
        byte_cnt_r <= 3'h0;
      end else if (sck_rise) begin
        in_sr_r   <= byte_in;
        bit_cnt_r <= bit_cnt_r + 3'h1;
        if (byte_done) begin
          if (byte_cnt_r != 3'h7) begin
            byte_cnt_r <= byte_cnt_r + 3'h1;
          end
          if (byte_cnt_r == 3'h0) begin
            opc_r <= byte_in;
          end
          if (byte_cnt_r >= 3'h1 && byte_cnt_r <= 3'h3) begin
            addr_r <= {addr_r[15:0], byte_in};
          end
          if (byte_cnt_r == 3'h1) begin
            data_r <= byte_in;
          end
        end
      end
    end
  end

  // ==========================================
  // Status read out, repeating until deselect
  logic [7:0] status_now;
  assign status_now = {nv_r, wel_r, busy_r};

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      out_sr_r  <= 8'h00;
      out_cnt_r <= 3'h0;
      so        <= 1'b0;
      so_en_n   <= 1'b1;
    end else if (ce) begin
      so_en_n <= state_r != ST_READ;
      if (state_r == ST_CMD && byte_done && byte_in == OPC_READ_STATUS_CMD) begin
        out_sr_r  <= status_now;
        out_cnt_r <= 3'h0;
      end else if (state_r == ST_READ && sck_fall) begin
        so        <= out_sr_r[7];
        out_cnt_r <= out_cnt_r + 3'h1;
        // Reload keeps a live copy, so polling sees busy drop
        out_sr_r  <= out_cnt_r == 3'h7 ? status_now : {out_sr_r[6:0], 1'b0};
      end
    end
  end

  // ==========================================
  // Command evaluation at deselect
  logic exec, need_ok, go_arr, go_ce, go_nv, go_sr, done;
  always_comb begin
    exec    = ce && cs_rise && state_r == ST_CMD && whole && byte_cnt_r != 3'h0;
    need_ok = 1'b0;
    if (is_array(opc_r)) begin
      need_ok = byte_cnt_r >= 3'h4;
    end else if (is_erase_all(opc_r)) begin
      need_ok = byte_cnt_r == 3'h1;
    end else if (is_nvreg(opc_r) || opc_r == OPC_WRITE_STATUS_CMD) begin
      need_ok = byte_cnt_r >= 3'h2;
    end
    go_arr = exec && need_ok && !busy_r && wel_r && is_array(opc_r)
          && !blk_prot(bp, addr_r[BLK_LSB+5:BLK_LSB]);
    go_ce  = exec && need_ok && !busy_r && wel_r && is_erase_all(opc_r)
          && bp == 4'h0;
    go_nv  = exec && need_ok && !busy_r && wel_r && is_nvreg(opc_r);
    go_sr  = exec && need_ok && !busy_r && wel_r && opc_r == OPC_WRITE_STATUS_CMD
          && !hw_lock;
    done   = ce && busy_r && cnt_r == '0;
  end

  // Volatile register setters fall through here untouched by the latch
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      wel_r <= 1'b0;
    end else if (done || (exec && opc_r == OPC_RST && rst_en_r)) begin
      wel_r <= 1'b0;
    end else if (exec && !busy_r && byte_cnt_r == 3'h1) begin
      if (opc_r == OPC_WRITE_ENABLE_CMD) begin
        wel_r <= 1'b1;
      end else if (opc_r == OPC_WRITE_DISABLE_CMD) begin
        wel_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      nv_r <= NV_RESET;
    end else if (go_sr) begin
      nv_r <= data_r[SR_STATUS_WRITE_DISABLE:SR_BP_LO];
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rst_en_r <= 1'b0;
    end else if (exec) begin
      rst_en_r <= opc_r == OPC_RSTEN;
    end
  end

  // Busy is driven by operation start, the timer, suspend/resume and reset, never by written status data
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      busy_r <= 1'b0;
      susp_r <= 1'b0;
      cnt_r  <= '0;
    end else if (ce) begin
      if (exec && opc_r == OPC_RST && rst_en_r) begin
        busy_r <= 1'b0;
        susp_r <= 1'b0;
        cnt_r  <= '0;
      end else if (go_arr || go_ce || go_nv || go_sr) begin
        busy_r <= 1'b1;
        cnt_r  <= CNT_W'(BUSY_CYCLES - 1);
      end else if (exec && busy_r && (opc_r == OPC_SUS_A || opc_r == OPC_SUS_B)) begin
        busy_r <= 1'b0;
        susp_r <= 1'b1;
      end else if (exec && susp_r && (opc_r == OPC_RES_A || opc_r == OPC_RES_B)) begin
        busy_r <= 1'b1;
        susp_r <= 1'b0;
      end else if (done) begin
        busy_r <= 1'b0;
      end else if (busy_r) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  // ==========================================
  // Operation request towards the memory core
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      op_go   <= 1'b0;
      op_kind <= 8'h00;
      op_addr <= 24'h000000;
    end else if (ce) begin
      op_go <= go_arr || go_ce || go_nv || go_sr;
      if (go_arr || go_ce || go_nv || go_sr) begin
        op_kind <= opc_r;
        op_addr <= addr_r;
      end
    end
  end

  assign status    = status_now;
  assign quad_pins = nv_r[SR_QE-SR_BP_LO];

  // ==========================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_go_needs_latch: assert property (op_go |-> $past(wel_r))
    else $error("operation started without write enable");
  a_go_sets_busy: assert property (op_go |-> busy_r && !$past(busy_r))
    else $error("start did not raise busy");
  a_ce_bp_zero: assert property (op_go && is_erase_all(op_kind) |-> bp == 4'h0)
    else $error("chip erase with protection set");
  a_region_free: assert property (op_go && is_array(op_kind)
      |-> !blk_prot(bp, op_addr[BLK_LSB+5:BLK_LSB]))
    else $error("program or erase in protected region");
  a_done_clear_wel: assert property ($fell(busy_r) && !susp_r |-> !wel_r)
    else $error("latch still set after completion");
  a_lock_holds_nv: assert property ($changed(nv_r) |-> $past(wel_r) && !$past(hw_lock))
    else $error("status bits changed while locked");
  a_write_enable_cmd_sets: assert property (exec && opc_r == OPC_WRITE_ENABLE_CMD && !busy_r
      && byte_cnt_r == 3'h1 |=> wel_r)
    else $error("write enable did not set latch");
  a_write_status_cmd_keep_wel: assert property (go_sr |=> wel_r ##1 busy_r)
    else $error("status write touched the latch");
  a_read_drive: assert property (state_r != ST_READ && ce |=> so_en_n)
    else $error("output driven outside status read");

endmodule // fsp_status_protect
`default_nettype wire

// File: shared/fsp_pkg.sv
`default_nettype none
package fsp_pkg;
  // ==========================================
  // Timing
  localparam int MCLK_MHZ     = 20;
  localparam int OP_TIME_NS   = 100000;
  localparam int BUSY_CYC_DEF = OP_TIME_NS * MCLK_MHZ / 1000;
  localparam int CNT_W        = 16;

  // ==========================================
  // Status bit positions and reset value
  localparam int        SR_BUSY  = 0;
  localparam int        SR_WEL   = 1;
  localparam int        SR_BP_LO = 2;
  localparam int        SR_QE    = 6;
  localparam int        SR_STATUS_WRITE_DISABLE  = 7;
  localparam logic [5:0] NV_RESET = 6'h00;
  localparam int        BLK_LSB  = 16;
  localparam logic [5:0] BLK_TOP = 6'h3f;

  // ==========================================
  // Opcodes
  localparam logic [7:0] OPC_WRITE_ENABLE_CMD  = 8'h06;
  localparam logic [7:0] OPC_WRITE_DISABLE_CMD  = 8'h04;
  localparam logic [7:0] OPC_READ_STATUS_CMD  = 8'h05;
  localparam logic [7:0] OPC_WRITE_STATUS_CMD  = 8'h01;
  localparam logic [7:0] OPC_PP    = 8'h02;
  localparam logic [7:0] OPC_PPQ_A = 8'h32;
  localparam logic [7:0] OPC_PPQ_B = 8'h38;
  localparam logic [7:0] OPC_SE_A  = 8'hd7;
  localparam logic [7:0] OPC_SE_B  = 8'h20;
  localparam logic [7:0] OPC_BE32  = 8'h52;
  localparam logic [7:0] OPC_BE64  = 8'hd8;
  localparam logic [7:0] OPC_CE_A  = 8'hc7;
  localparam logic [7:0] OPC_CE_B  = 8'h60;
  localparam logic [7:0] OPC_WRFN  = 8'h42;
  localparam logic [7:0] OPC_SET_READ_PARAMS_NV_CMD = 8'h65;
  localparam logic [7:0] OPC_SERNV = 8'h85;
  localparam logic [7:0] OPC_INFO_ROW_ERASE_CMD  = 8'h64;
  localparam logic [7:0] OPC_IRP   = 8'h62;
  localparam logic [7:0] OPC_WRAB  = 8'h15;
  localparam logic [7:0] OPC_RDERP = 8'h81;
  localparam logic [7:0] OPC_SUS_A = 8'h75;
  localparam logic [7:0] OPC_SUS_B = 8'hb0;
  localparam logic [7:0] OPC_RES_A = 8'h7a;
  localparam logic [7:0] OPC_RES_B = 8'h30;
  localparam logic [7:0] OPC_RSTEN = 8'h66;
  localparam logic [7:0] OPC_RST   = 8'h99;

  // ==========================================
  // Types
  typedef struct packed {
    logic       status_write_disable;
    logic       quad_pin_enable;
    logic [3:0] block_protect;
    logic       write_enable_latch;
    logic       busy_flag;
  } fsp_status_type;

  typedef struct packed {
    logic sck;
    logic cs_n;
    logic si;
    logic wp_n;
  } fsp_pins_type;

  localparam fsp_pins_type PINS_IDLE = 4'h5;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CMD  = 2'b01,
    ST_READ = 2'b10,
    ST_SKIP = 2'b11
  } fsp_state_type;
endpackage
`default_nettype wire

// File: tb/fsp_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Host serial controller, mode 0, whole bytes only
module fsp_host_model
  import fsp_pkg::*;
(
  input  wire logic         mclk,
  input  wire logic         so,
  output var  fsp_pins_type pins
);
  initial pins = PINS_IDLE;

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic set_wp(input logic v);
    pins.wp_n = v;
  endtask

  // Clock stands low between frames; half period of 4 system cycles
  // Data is sampled late in the high phase, well after the shift
  task automatic frame(input logic [39:0] tx, input int nb, input int nrd,
                       output logic [15:0] rd);
    rd = 16'h0000;
    tick(1);
    pins.cs_n = 1'b0;
    for (int i = 0; i < nb * 8 + nrd; i++) begin
      pins.si = (i < nb * 8) ? tx[39 - i] : ~pins.si;
      tick(4);
      pins.sck = 1'b1;
      tick(4);
      rd = {rd[14:0], so};
      pins.sck = 1'b0;
    end
    tick(4);
    pins.cs_n = 1'b1;
    // Released data line must not keep showing the last bit
    pins.si = ~pins.si;
    tick(8);
  endtask
endmodule // fsp_host_model
`default_nettype wire

// File: tb/flash_status_write_protect_test.sv
`timescale 1ns/10ps
`default_nettype none
module flash_status_write_protect_test
  import fsp_pkg::*;
;
  // ==========================================
  // Set-up
  localparam int BUSY_N = 600;
  localparam logic [7:0] GATED [16] = '{OPC_PP, OPC_PPQ_A, OPC_PPQ_B, OPC_SE_A, OPC_SE_B,
    OPC_BE32, OPC_BE64, OPC_CE_A, OPC_CE_B, OPC_WRITE_STATUS_CMD, OPC_WRFN, OPC_SET_READ_PARAMS_NV_CMD, OPC_SERNV,
    OPC_INFO_ROW_ERASE_CMD, OPC_IRP, OPC_WRAB};
  logic           mclk = 1'b0;
  logic           nrst = 1'b0;
  logic           ce = 1'b1;
  fsp_pins_type   pins;
  logic           so, so_en_n, quad_pins, op_go;
  fsp_status_type status;
  logic [7:0]     op_kind;
  logic [23:0]    op_addr;
  logic [15:0]    rd;
  int             mismatches = 0;
  int             checked = 0;
  int             go_cnt = 0;

  initial forever #25 mclk = ~mclk;

  fsp_status_protect #(.BUSY_CYCLES(BUSY_N)) i_fsp_status_protect (.mclk(mclk), .nrst(nrst),
    .ce(ce), .sck(pins.sck), .cs_n(pins.cs_n), .si(pins.si), .wp_n(pins.wp_n), .so(so),
    .so_en_n(so_en_n), .status(status), .quad_pins(quad_pins), .op_go(op_go),
    .op_kind(op_kind), .op_addr(op_addr));
  fsp_host_model i_fsp_host_model (.mclk(mclk), .so(so), .pins(pins));

  always @(posedge mclk) if (op_go === 1'b1) go_cnt++;

  // ==========================================
  // Helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic cmd(input logic [39:0] tx, input int nb);
    i_fsp_host_model.frame(tx, nb, 0, rd);
  endtask

  // Bounded wait, so a stuck busy flag is reported rather than hung on
  task automatic idle();
    for (int i = 0; i < 3 * BUSY_N && status.busy_flag !== 1'b0; i++) @(posedge mclk);
    #1;
    chk(16'(status.busy_flag), 16'h0);
  endtask

  task automatic wcmd(input logic [39:0] tx, input int nb);
    cmd({OPC_WRITE_ENABLE_CMD, 32'h0}, 1);
    cmd(tx, nb);
    idle();
  endtask

  task automatic wsr(input logic [7:0] d);
    wcmd({OPC_WRITE_STATUS_CMD, d, 24'h0}, 2);
  endtask

  function automatic int nb(input logic [7:0] o);
    return (o == OPC_CE_A || o == OPC_CE_B) ? 1 : 5;
  endfunction

  function automatic logic prot(input logic [3:0] bp, input int blk);
    case (bp)
      4'h0, 4'hf: return 1'b0;
      4'h7, 4'h8: return 1'b1;
      default: return (bp < 4'h7) ? (blk >= 64 - (1 << (bp - 1))) : (blk < (64 >> (bp - 8)));
    endcase
  endfunction

  // ==========================================
  // Tests
  initial begin
    logic [39:0] tx;
    logic [7:0]  opc;
    logic [7:0]  d;
    int          g;
    int          blk;
    int          e;
    void'($urandom(17978));
    repeat (2) @(posedge mclk);
    #1 nrst = 1'b1;
    tick_wait();
    chk({status, quad_pins, so_en_n}, {8'h00, 1'b0, 1'b1});
    cmd({OPC_WRITE_ENABLE_CMD, 32'h0}, 1);
    chk(status, 8'h02);
    cmd({OPC_WRITE_DISABLE_CMD, 32'h0}, 1);
    chk(status, 8'h00);
    // A frame sent while the enable is low must leave no trace
    ce = 1'b0;
    cmd({OPC_WRITE_ENABLE_CMD, 32'h0}, 1);
    ce = 1'b1;
    tick_wait();
    chk(status, 8'h00);
    foreach (GATED[k]) begin
      opc = GATED[k];
      g = go_cnt;
      tx = {opc, (opc == OPC_WRITE_STATUS_CMD) ? 8'h00 : 8'($urandom), 16'($urandom), 8'($urandom)};
      cmd(tx, nb(opc));
      chk(16'(go_cnt - g), 16'h0);
      cmd({OPC_WRITE_ENABLE_CMD, 32'h0}, 1);
      cmd(tx, nb(opc));
      chk(16'(go_cnt - g), 16'h1);
      chk(op_kind, opc);
      if (opc inside {OPC_PP, OPC_PPQ_A, OPC_PPQ_B, OPC_SE_A, OPC_SE_B, OPC_BE32, OPC_BE64})
        chk(op_addr[15:0], tx[23:8]);
      cmd(tx, nb(opc));
      i_fsp_host_model.frame({OPC_READ_STATUS_CMD, 32'h0}, 1, 16, rd);
      chk(rd, 16'h0303);
      chk(16'(go_cnt - g), 16'h1);
      idle();
      chk(status, 8'h00);
    end
    d = {2'b10, 4'($urandom), 2'b11};
    wsr(d);
    chk(status, {d[7:2], 2'b00});
    i_fsp_host_model.set_wp(1'b0);
    g = go_cnt;
    wsr(8'h00);
    chk(status, {d[7:2], 2'b10});
    chk(16'(go_cnt - g), 16'h0);
    i_fsp_host_model.set_wp(1'b1);
    wsr(8'hc0);
    chk({status, quad_pins}, {8'hc0, 1'b1});
    i_fsp_host_model.set_wp(1'b0);
    wsr(8'h00);
    chk({status, quad_pins}, 9'h000);
    i_fsp_host_model.set_wp(1'b1);
    for (int bp = 0; bp < 16; bp++) begin
      wsr({2'b00, 4'(bp), 2'b00});
      chk(status, {2'b00, 4'(bp), 2'b00});
      // Corner blocks on most codes, a random block on the rest
      blk = (bp % 2) ? 63 : ((bp % 4 == 0) ? 0 : int'($urandom % 64));
      g = go_cnt;
      e = prot(4'(bp), blk) ? 0 : 1;
      wcmd({OPC_PP, 2'b00, 6'(blk), 24'($urandom)}, 5);
      chk(16'(go_cnt - g), 16'(e));
      wcmd({(bp % 2) ? OPC_CE_A : OPC_CE_B, 32'h0}, 1);
      chk(16'(go_cnt - g), 16'(e + (bp == 0)));
    end
    end_of_test();
  end

  task automatic tick_wait();
    repeat (4) @(posedge mclk);
    #1;
  endtask

  initial begin
    repeat (100000) @(posedge mclk);
    mismatches++;
    end_of_test();
  end
endmodule // flash_status_write_protect_test
`default_nettype wire
